// ==== core/adcsi_top.sv ====
// Digital control and serial readout of a four-channel sampling converter.
// Assumes a converter core that presents its result word on the system clock,
// and a host that drives strobes asynchronously and may supply the bit clock.
`timescale 1ns/1ps
`include "adcsi_defines.svh"

module adcsi_top
    import adcsi_pkg::*;
#(
    parameter adcsi_cnt_t CONV_CYCLES    = adcsi_cnt_t'(`ADCSI_CONV_CYCLES),
    parameter adcsi_cnt_t QUARTER_CYCLES = adcsi_cnt_t'(`ADCSI_QUARTER_CYCLES)
) (
    input  wire logic                   sys_clk,
    input  wire logic                   resetn,
    input  wire logic                   cs_n,
    input  wire logic                   read_conv,
    input  wire logic                   chan_latch_strobe_a_n,
    input  wire logic                   chan_latch_strobe_b_n,
    input  wire logic                   chan_addr_hi,
    input  wire logic                   chan_addr_lo,
    input  wire logic                   bit_clock_source_sel,
    input  wire logic                   power_down_in,
    input  wire adcsi_pkg::adcsi_word_t conv_core_result,
    input  wire logic                   serial_bit_clock_in,
    output      logic                   serial_bit_clock_out,
    output      logic                   serial_bit_clock_oe_n,
    output      logic                   serial_data,
    output      logic                   frame_sync,
    output      logic                   busy_n,
    output      logic                   sample_hold,
    output      logic [3:0]             analog_input_sel
);
    import adcsi_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        adcsi_state_e state;
        adcsi_cnt_t   conv_cnt;
        logic         prev_or_n;
        logic         prev_cs_n;
        logic         prev_rc;
        logic         busy_n;
        logic         sample_pulse;
        adcsi_word_t  result;
        logic [1:0]   chan_sel;
        adcsi_word_t  ext_word;
        logic         ext_req;
        logic         tx_active;
        logic [4:0]   tx_bits;
        logic [1:0]   tx_q;
        adcsi_cnt_t   tx_div;
        adcsi_word_t  tx_shift;
        logic         int_clk;
        logic         int_data;
    } adcsi_core_s;

    localparam adcsi_core_s CORE_RST = '{
        state:        ADCSI_IDLE,
        conv_cnt:     '0,
        prev_or_n:    1'b1,
        prev_cs_n:    1'b1,
        prev_rc:      1'b1,
        busy_n:       1'b1,
        sample_pulse: 1'b0,
        result:       `ADCSI_RESULT_RST,
        chan_sel:     `ADCSI_CHAN_RST,
        ext_word:     `ADCSI_RESULT_RST,
        ext_req:      1'b0,
        tx_active:    1'b0,
        tx_bits:      5'h00,
        tx_q:         2'h0,
        tx_div:       '0,
        tx_shift:     `ADCSI_RESULT_RST,
        int_clk:      1'b0,
        int_data:     1'b0
    };

    adcsi_core_s s;
    adcsi_core_s next_s;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    logic [7:0] pin_s;
    logic       cs_s;
    logic       rc_s;
    logic       wa_s;
    logic       wb_s;
    logic [1:0] addr_s;
    logic       sel_s;
    logic       pd_s;

    adcsi_sync #(
        .W       (8),
        .RST_VAL (`ADCSI_PIN_SYNC_RST)
    ) u_pin_sync (
        .clk    (sys_clk),
        .resetn (resetn),
        .d      ({power_down_in, bit_clock_source_sel, chan_addr_hi, chan_addr_lo,
                  chan_latch_strobe_b_n, chan_latch_strobe_a_n, read_conv, cs_n}),
        .q      (pin_s)
    );

    assign cs_s   = pin_s[0];
    assign rc_s   = pin_s[1];
    assign wa_s   = pin_s[2];
    assign wb_s   = pin_s[3];
    assign addr_s = pin_s[5:4];
    assign sel_s  = pin_s[6];
    assign pd_s   = pin_s[7];

    ////////////////////////////////////////////////////////////////////////////
    // Start decoding

    logic or_n;
    logic conv_req;
    logic read_req;
    logic conv_start;
    logic q_wrap;

    // Strobes are ORed, so either may fall last to start a conversion
    assign or_n       = cs_s | rc_s;
    assign conv_req   = s.prev_or_n & ~or_n;
    assign read_req   = (s.prev_cs_n & ~cs_s & rc_s) | (~s.prev_rc & rc_s & ~cs_s);
    assign conv_start = conv_req & ~pd_s & (s.state == ADCSI_IDLE);
    assign q_wrap     = (s.tx_div == QUARTER_CYCLES - adcsi_cnt_t'(1));

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb
    begin
        next_s              = s;
        next_s.prev_or_n    = or_n;
        next_s.prev_cs_n    = cs_s;
        next_s.prev_rc      = rc_s;
        next_s.sample_pulse = 1'b0;

        // Channel latch follows the address while both strobes are low
        if (!(wa_s | wb_s))
            next_s.chan_sel = addr_s;

        case (s.state)
            ADCSI_IDLE:
            begin
                if (conv_start)
                begin
                    next_s.state        = ADCSI_CONV;
                    next_s.conv_cnt     = '0;
                    next_s.busy_n       = 1'b0;
                    next_s.sample_pulse = 1'b1;
                    if (!sel_s)
                    begin
                        // Previous result goes out during this conversion
                        next_s.tx_active = 1'b1;
                        next_s.tx_shift  = s.result;
                        next_s.tx_bits   = 5'h00;
                        next_s.tx_q      = 2'h0;
                        next_s.tx_div    = '0;
                        next_s.int_data  = s.result[`ADCSI_WORD_BITS-1];
                    end
                end
            end
            ADCSI_CONV:
            begin
                // Further starts are not looked at until the result is loaded
                if (s.conv_cnt == CONV_CYCLES - adcsi_cnt_t'(1))
                    next_s.state = ADCSI_LOAD;
                else
                    next_s.conv_cnt = s.conv_cnt + adcsi_cnt_t'(1);
            end
            ADCSI_LOAD:
            begin
                next_s.result = conv_core_result;
                next_s.busy_n = 1'b1;
                next_s.state  = ADCSI_IDLE;
            end
            default:
            begin
                next_s.state  = ADCSI_IDLE;
                next_s.busy_n = 1'b1;
            end
        endcase

        // External mode: snapshot is the old word mid-conversion, the new one after
        if (read_req && sel_s)
        begin
            next_s.ext_word = s.result;
            next_s.ext_req  = ~s.ext_req;
        end

        // Internal bit clock: four quarters per bit, high in the middle two
        if (s.tx_active)
        begin
            if (q_wrap)
            begin
                next_s.tx_div = '0;
                next_s.tx_q   = s.tx_q + 2'h1;
                case (s.tx_q)
                    2'h0:
                        next_s.int_clk = 1'b1;
                    2'h2:
                        next_s.int_clk = 1'b0;
                    2'h3:
                    begin
                        if (s.tx_bits == `ADCSI_LAST_BIT)
                            next_s.tx_active = 1'b0;
                        else
                        begin
                            // Data moves only in the low quarter before a rise
                            next_s.tx_bits  = s.tx_bits + 5'h01;
                            next_s.tx_shift = {s.tx_shift[`ADCSI_WORD_BITS-2:0], 1'b0};
                            next_s.int_data = s.tx_shift[`ADCSI_WORD_BITS-2];
                        end
                    end
                    default:
                        next_s.int_clk = s.int_clk;
                endcase
            end
            else
                next_s.tx_div = s.tx_div + adcsi_cnt_t'(1);
        end
    end

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            s <= CORE_RST;
        else
            s <= next_s;
    end

    ////////////////////////////////////////////////////////////////////////////
    // External clock domain

    logic link_data;
    logic link_sync;

    adcsi_ext_link u_ext_link (
        .link_clk    (serial_bit_clock_in),
        .resetn      (resetn),
        .read_toggle (s.ext_req),
        .read_word   (s.ext_word),
        .link_data   (link_data),
        .frame_sync  (link_sync)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    // Pin is released while the host supplies the clock
    assign serial_bit_clock_oe_n = sel_s;
    assign serial_bit_clock_out  = s.int_clk;
    assign serial_data           = sel_s ? link_data : s.int_data;
    assign frame_sync            = link_sync;
    assign busy_n                = s.busy_n;
    assign sample_hold           = s.sample_pulse;

    // One select line per analog input
    genvar ch;
    generate
        for (ch = 0; ch < 4; ch++)
        begin : g_chan
            assign analog_input_sel[ch] = (s.chan_sel == 2'(ch));
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge sys_clk);
    endclocking

    default disable iff (!resetn);

    a_busy_on_start: assert property (
        conv_start |=> !busy_n [*2])
        else $error("busy not low after a conversion start");

    a_busy_until_load: assert property (
        $rose(busy_n) |-> ($past(s.state) == ADCSI_LOAD) && (s.result == $past(conv_core_result)))
        else $error("busy released before the result was loaded");

    a_pd_refuses: assert property (
        (pd_s && s.state == ADCSI_IDLE) |=> s.state == ADCSI_IDLE && busy_n)
        else $error("conversion started during power down");

    a_result_kept: assert property (
        !$stable(s.result) |-> $past(s.state) == ADCSI_LOAD)
        else $error("result changed outside a load");

    a_busy_ignores: assert property (
        (s.state == ADCSI_CONV && s.conv_cnt == adcsi_cnt_t'(0)) |=> s.conv_cnt == adcsi_cnt_t'(1))
        else $error("running conversion disturbed");

    a_latch_open: assert property (
        (!wa_s && !wb_s) |=> s.chan_sel == $past(addr_s))
        else $error("channel latch not transparent");

    a_latch_hold: assert property (
        (wa_s || wb_s) |=> $stable(s.chan_sel))
        else $error("channel latch moved while a strobe was high");

    a_chan_onehot: assert property (
        $onehot(analog_input_sel) && analog_input_sel[s.chan_sel])
        else $error("channel select not one-hot on the addressed input");

    a_data_steady: assert property (
        ($rose(s.int_clk) || $fell(s.int_clk)) |-> $stable(s.int_data))
        else $error("internal data moved on a clock edge");

    a_data_low_phase: assert property (
        (s.tx_active && $changed(s.int_data)) |-> !s.int_clk && s.tx_q == 2'h0)
        else $error("internal data moved outside the low quarter");

    a_word_length: assert property (
        $fell(s.tx_active) |-> $past(s.tx_bits) == `ADCSI_LAST_BIT)
        else $error("internal word not sixteen bits long");

    a_clock_idle_low: assert property (
        !s.tx_active |-> !s.int_clk)
        else $error("internal bit clock not parked low");

    a_msb_first: assert property (
        (conv_start && !sel_s) |=> s.int_data == $past(s.result[`ADCSI_WORD_BITS-1]))
        else $error("internal word does not begin with the MSB");

    a_read_snapshot: assert property (
        (read_req && sel_s) |=> s.ext_word == $past(s.result) && s.ext_req != $past(s.ext_req))
        else $error("external read did not capture the current result");

    // Internal mode must never wake the link frame logic
    a_marker_ext_only: assert property (
        (read_req && !sel_s) |=> $stable(s.ext_req))
        else $error("read toggled the link in internal clock mode");

    a_start_on_fall: assert property (
        conv_start |=> sample_hold && s.state == ADCSI_CONV)
        else $error("conversion start not taken");

endmodule : adcsi_top

// ==== core/adcsi_defines.svh ====
// Constants of the serial conversion interface: timing, widths, reset values.
// Assumes a 125 MHz system clock; included by the package, the top and the link module.
//
// Summary of operation
// - External mode: frame pulse one bit period wide
// - Frame pulse only in external clock mode
// - Internal mode: sixteen bit clocks per start
// - Result shifted out MSB first from register
// - External mode: host bit clock governs every shift
// - External read before or after conversion allowed
// - Latch enable is OR of both strobes
// - Both strobes low makes the latch transparent
// - Address 00..11 selects inputs one..four
// - Chip select fall, read low, starts conversion
// - Chip select fall, read high, starts external readout
// - Busy low from start until result loaded
// - Data changes only with the active clock
// - Read fall converts, read rise enables external readout
// - Source select low drives clock, high receives
// - Power down refuses starts, keeps result
// - Internal mode sends previous result, clock idles low
`ifndef ADCSI_DEFINES_SVH
`define ADCSI_DEFINES_SVH

`define ADCSI_WORD_BITS      16
`define ADCSI_CNT_BITS       16
`define ADCSI_SYS_CLK_NS     8
`define ADCSI_CONV_TIME_NS   4000
`define ADCSI_QUARTER_NS     32
// Least times: round up to whole cycles
`define ADCSI_CONV_CYCLES    ((`ADCSI_CONV_TIME_NS + `ADCSI_SYS_CLK_NS - 1) / `ADCSI_SYS_CLK_NS)
`define ADCSI_QUARTER_CYCLES ((`ADCSI_QUARTER_NS + `ADCSI_SYS_CLK_NS - 1) / `ADCSI_SYS_CLK_NS)
`define ADCSI_LAST_BIT       5'h0F
`define ADCSI_RESULT_RST     16'h0000
`define ADCSI_CHAN_RST       2'h0
`define ADCSI_PIN_SYNC_RST   8'h4F

`endif

// ==== core/adcsi_pkg.sv ====
// Types shared by the serial conversion interface modules.
// Assumes the defines header sits in the include path.
`include "adcsi_defines.svh"

package adcsi_pkg;

    typedef logic [`ADCSI_WORD_BITS-1:0] adcsi_word_t;
    typedef logic [`ADCSI_CNT_BITS-1:0]  adcsi_cnt_t;

    typedef enum logic [1:0]
    {
        ADCSI_IDLE = 2'h0,
        ADCSI_CONV = 2'h1,
        ADCSI_LOAD = 2'h3
    } adcsi_state_e;

endpackage : adcsi_pkg

// ==== core/adcsi_sync.sv ====
// Two-flop synchroniser for a group of asynchronous levels.
// Assumes each bit is a slow level; no bus coherence across bits.
`timescale 1ns/1ps

module adcsi_sync #(
    parameter int           W       = 8,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         clk,
    input  wire logic         resetn,
    input  wire logic [W-1:0] d,
    output      logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } adcsi_sync_s;

    adcsi_sync_s s;
    adcsi_sync_s next_s;

    always_comb
    begin
        next_s.meta   = d;
        next_s.stable = s.meta;
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            s <= '{meta: RST_VAL, stable: RST_VAL};
        else
            s <= next_s;
    end

    assign q = s.stable;

endmodule : adcsi_sync

// ==== core/adcsi_ext_link.sv ====
// Link side of external bit clock mode: shifts the word on the host clock.
// Assumes the word is held steady in the system domain while a request toggles.
`timescale 1ns/1ps
`include "adcsi_defines.svh"

module adcsi_ext_link
    import adcsi_pkg::*;
(
    input  wire logic              link_clk,
    input  wire logic              resetn,
    input  wire logic              read_toggle,
    input  wire adcsi_pkg::adcsi_word_t read_word,
    output      logic              link_data,
    output      logic              frame_sync
);
    typedef struct packed {
        logic        req_meta;
        logic        req_stable;
        logic        req_seen;
        adcsi_word_t shift;
        logic [4:0]  bits_left;
        logic        data;
        logic        sync;
    } adcsi_link_s;

    adcsi_link_s s;
    adcsi_link_s next_s;

    always_comb
    begin
        next_s            = s;
        next_s.req_meta   = read_toggle;
        next_s.req_stable = s.req_meta;
        next_s.sync       = 1'b0;
        if (s.req_stable != s.req_seen)
        begin
            // New frame: MSB and marker leave together on this edge
            next_s.req_seen  = s.req_stable;
            next_s.data      = read_word[`ADCSI_WORD_BITS-1];
            next_s.shift     = {read_word[`ADCSI_WORD_BITS-2:0], 1'b0};
            next_s.bits_left = `ADCSI_LAST_BIT;
            next_s.sync      = 1'b1;
        end
        else if (s.bits_left != 5'h00)
        begin
            next_s.data      = s.shift[`ADCSI_WORD_BITS-1];
            next_s.shift     = {s.shift[`ADCSI_WORD_BITS-2:0], 1'b0};
            next_s.bits_left = s.bits_left - 5'h01;
        end
    end

    // Clock may stop between frames; a request crosses on two host edges, the frame starts on the third
    always_ff @(posedge link_clk or negedge resetn)
    begin
        if (!resetn)
            s <= '0;
        else
            s <= next_s;
    end

    assign link_data  = s.data;
    assign frame_sync = s.sync;

    a_sync_one_period: assert property (@(posedge link_clk) disable iff (!resetn)
        frame_sync |=> !frame_sync)
        else $error("frame marker longer than one bit period");

    a_sync_with_msb: assert property (@(posedge link_clk) disable iff (!resetn)
        frame_sync |-> link_data == $past(read_word[`ADCSI_WORD_BITS-1]))
        else $error("frame marker not aligned to the MSB");

    a_shift_on_request: assert property (@(posedge link_clk) disable iff (!resetn)
        (s.bits_left == 5'h00 && s.req_stable == s.req_seen) |=> $stable(s.data))
        else $error("data shifted without a host read");

endmodule : adcsi_ext_link

// ==== bench/adcsi_host_model.sv ====
// Host side model: supplies the external bit clock and captures the word.
// Assumes the bench calls run_frame only while external clock mode is chosen.
`timescale 1ns/1ps

module adcsi_host_model (
    output logic        link_clk,
    input  wire logic   serial_data,
    input  wire logic   frame_sync,
    output logic [15:0] word,
    output int          frames
);
    int left = 0;

    initial
    begin
        link_clk = 1'b0;
        word = 16'h0000;
        frames = 0;
    end

    // Clock stands low between frames, so no stray shift reaches the link
    task automatic run_frame(input int edges);
        #3.3;
        repeat (edges)
        begin
            #7.5 link_clk = 1'b1;
            #7.5 link_clk = 1'b0;
        end
    endtask : run_frame

    always @(posedge link_clk)
    begin
        if (frame_sync)
        begin
            frames <= frames + 1;
            word   <= {15'h0000, serial_data};
            left   <= 15;
        end
        else if (left > 0)
        begin
            word <= {word[14:0], serial_data};
            left <= left - 1;
        end
    end
endmodule : adcsi_host_model

// ==== bench/test_adcsi_top.sv ====
// Self-checking bench of the serial conversion interface top.
// Assumes the host model file is compiled first; strobes driven on falling edges.
`timescale 1ns/1ps

module test_adcsi_top;
    import adcsi_pkg::*;
    // Short conversion keeps the run small; readout of 64 cycles still fits
    localparam adcsi_cnt_t CONV    = 16'h0050;
    localparam int         TIMEOUT = 20000;

    logic        sys_clk, resetn, cs_n, read_conv, wr_a_n, wr_b_n, a_hi, a_lo, sel, pd;
    logic        host_clk, link_pin, clk_out, oe_n, sdata, fsync, busy_n, s_h;
    adcsi_word_t result;
    logic [3:0]  in_sel;
    logic [15:0] host_word;
    int          host_frames;
    int          miscompares = 0;
    int          compares = 0;
    int          cycles = 0;

    // Pin level: device drives while its enable is low, else the host does
    assign link_pin = oe_n ? host_clk : clk_out;

    adcsi_top #(.CONV_CYCLES(CONV), .QUARTER_CYCLES(16'h0001)) dut_u (
        .sys_clk(sys_clk), .resetn(resetn), .cs_n(cs_n), .read_conv(read_conv),
        .chan_latch_strobe_a_n(wr_a_n), .chan_latch_strobe_b_n(wr_b_n),
        .chan_addr_hi(a_hi), .chan_addr_lo(a_lo), .bit_clock_source_sel(sel),
        .power_down_in(pd), .conv_core_result(result), .serial_bit_clock_in(link_pin),
        .serial_bit_clock_out(clk_out), .serial_bit_clock_oe_n(oe_n), .serial_data(sdata),
        .frame_sync(fsync), .busy_n(busy_n), .sample_hold(s_h), .analog_input_sel(in_sel));

    adcsi_host_model host_u (.link_clk(host_clk), .serial_data(sdata), .frame_sync(fsync),
        .word(host_word), .frames(host_frames));

    always #4 sys_clk = ~sys_clk;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic print_verdict;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : print_verdict

    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == TIMEOUT)
        begin
            miscompares++;
            print_verdict();
        end
    end

    task automatic settle(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : settle

    // Combined select goes high long enough to pass the synchroniser, then falls
    task automatic start_conv;
        @(negedge sys_clk);
        cs_n = 1'b1;
        read_conv = 1'b0;
        settle(3);
        cs_n = 1'b0;
    endtask : start_conv

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_channel;
        for (int i = 0; i < 4; i++)
        begin
            {a_hi, a_lo} = 2'(i);
            settle(6);
            chk("input select", 16'(4'h1 << i), 16'(in_sel));
        end
        for (int j = 0; j < 2; j++)
        begin
            {wr_a_n, wr_b_n} = j ? 2'h1 : 2'h2;
            {a_hi, a_lo} = 2'(j + 1);
            settle(6);
            chk("held select", 16'(4'h1 << (j ? 1 : 3)), 16'(in_sel));
            {wr_a_n, wr_b_n} = 2'h0;
            settle(6);
            chk("opened select", 16'(4'h1 << (j + 1)), 16'(in_sel));
        end
    endtask : t_channel

    task automatic watch_conv(input adcsi_word_t exp_word, input bit poke);
        int          n, rises, pulses, bad, w;
        logic        prev_clk, prev_dat;
        adcsi_word_t got;
        {n, rises, pulses, bad, w} = '0;
        {prev_clk, prev_dat, got} = '0;
        while (busy_n !== 1'b0 && w < 10)
        begin
            settle(1);
            w++;
        end
        while (busy_n === 1'b0 && n < 200)
        begin
            if (s_h === 1'b1)
                pulses++;
            if (clk_out === 1'b1 && prev_clk === 1'b0)
            begin
                rises++;
                got = {got[14:0], sdata};
            end
            if (clk_out === 1'b1 && prev_clk === 1'b1 && sdata !== prev_dat)
                bad++;
            prev_clk = clk_out;
            prev_dat = sdata;
            if (poke && n == 20)
                cs_n = 1'b1;
            if (poke && n == 24)
                cs_n = 1'b0;
            settle(1);
            n++;
        end
        chk("busy low cycles", 16'(CONV) + 16'h0001, 16'(n));
        chk("bit clock pulses", 16'h0010, 16'(rises));
        chk("shifted word", exp_word, got);
        chk("sample pulses", 16'h0001, 16'(pulses));
        chk("unsteady bits", 16'h0000, 16'(bad));
        chk("idle bit clock", 16'h0000, 16'(clk_out));
    endtask : watch_conv

    task automatic t_internal;
        result = 16'hA5C3;
        settle(4);
        chk("bit clock enable", 16'h0000, 16'(oe_n));
        start_conv();
        watch_conv(16'h0000, 1'b0);
        result = 16'h3C5A;
        start_conv();
        watch_conv(16'hA5C3, 1'b1);
        chk("marker in internal mode", 16'h0000, 16'(fsync));
    endtask : t_internal

    task automatic t_power_down;
        int seen;
        seen = 0;
        pd = 1'b1;
        settle(4);
        start_conv();
        repeat (20)
        begin
            settle(1);
            if (busy_n !== 1'b1)
                seen++;
        end
        chk("refused start", 16'h0000, 16'(seen));
        pd = 1'b0;
    endtask : t_power_down

    task automatic ext_read(input adcsi_word_t exp_word);
        int f0;
        f0 = host_frames;
        settle(1);
        read_conv = 1'b1;
        cs_n = 1'b1;
        settle(3);
        cs_n = 1'b0;
        settle(5);
        host_u.run_frame(24);
        chk("frame markers", 16'h0001, 16'(host_frames - f0));
        chk("external word", exp_word, host_word);
        settle(1);
        cs_n = 1'b1;
    endtask : ext_read

    task automatic t_external;
        int n;
        n = 0;
        sel = 1'b1;
        settle(4);
        chk("bit clock enable", 16'h0001, 16'(oe_n));
        ext_read(16'h3C5A);
        result = 16'h96E1;
        start_conv();
        settle(6);
        ext_read(16'h3C5A);
        while (busy_n !== 1'b1 && n < 200)
        begin
            settle(1);
            n++;
        end
        ext_read(16'h96E1);
    endtask : t_external

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        sys_clk = 1'b0;
        cs_n = 1'b1;
        result = 16'h0000;
        {resetn, read_conv, wr_a_n, wr_b_n, a_hi, a_lo, sel, pd} = 8'h00;
        settle(5);
        chk("reset outputs", 16'h0181, 16'({busy_n, oe_n, fsync, s_h, clk_out, in_sel}));
        resetn = 1'b1;
        settle(4);
        t_channel();
        t_internal();
        t_power_down();
        t_external();
        print_verdict();
    end
endmodule : test_adcsi_top
